//--- rtl/adc_out_defines.vh
`ifndef ADC_OUT_DEFINES_VH
`define ADC_OUT_DEFINES_VH

`define WORD_W        12
`define LATENCY       11
`define LAT_W         4
`define FIFO_DEPTH    4
`define FIFO_AW       2
`define CODE_MAX_OB   12'hFFF
`define CODE_MIN_OB   12'h000
`define CODE_MID_OB   12'h800
`define MSB           11
`define DIV_RATIO     2
`define CNT_ZERO      4'h0
`define CNT_ONE       4'h1

`endif

//--- rtl/word_fifo.v
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_q];

  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // word_fifo
`default_nettype wire

//--- rtl/sample_pipe.v
`timescale 1ns/100ps
`default_nettype none
`include "adc_out_defines.vh"
module sample_pipe #(
  parameter WIDTH = 13,
  parameter DEPTH = 11
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // stage advance and data
  input  wire             adv,
  input  wire [WIDTH-1:0] in_data,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] stage_q [0:DEPTH-1];
  integer i;

  // fixed-depth shift, moves only on a conversion strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage_q[i] <= {WIDTH{1'b0}};
      end
    end else if (adv) begin
      stage_q[0] <= in_data;
      for (i = 1; i < DEPTH; i = i + 1) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign out_data = stage_q[DEPTH-1];
endmodule // sample_pipe
`default_nettype wire

//--- rtl/adc_output_format_timing.v
`timescale 1ns/100ps
`default_nettype none
`include "adc_out_defines.vh"
module adc_output_format_timing (
  // clock and reset
  input  wire                 clk,
  input  wire                 rst_b,
  // sampling clock, taken as synchronous levels
  input  wire                 sample_clk_true,
  input  wire                 sample_clk_comp,
  // quantised analog value, offset binary, plus range flags
  input  wire [`WORD_W-1:0]   analog_code,
  input  wire                 above_full_scale,
  input  wire                 below_full_scale,
  // straps; a floating pin is modelled as low (pulldown)
  input  wire                 half_rate_select,
  input  wire                 format_offset_bin,
  // parallel output bus
  output reg  [`WORD_W-1:0]   sample_word_true,
  output reg  [`WORD_W-1:0]   sample_word_comp,
  output reg                  overrange_true,
  output reg                  overrange_comp,
  output reg                  out_clk_true,
  output reg                  out_clk_comp,
  // buffered stream
  output wire                 word_valid,
  input  wire                 word_ready
);
  reg                 clk_true_q;
  reg                 clk_comp_q;
  reg                 div_q;
  reg                 conv_clk_q;
  reg  [`LAT_W-1:0]   fill_q;
  reg  [`WORD_W-1:0]  ob_code;
  reg                 or_flag;
  wire                rise;
  wire                conv;
  wire [`WORD_W:0]    pipe_out;
  wire [`WORD_W:0]    fifo_out;
  wire                fifo_in_ready;
  wire                fifo_in_valid;
  wire [`WORD_W-1:0]  fmt_word;
  wire                drain_ready;

  // one word per data clock pulse: no pop while a pulse is pending or high,
  // so the bus cannot change before the receiver's capture edge
  assign drain_ready = word_ready & ~conv_clk_q & ~out_clk_true;

  // true rise coincides with complementary fall
  assign rise = sample_clk_true & ~clk_true_q &
                ~sample_clk_comp & clk_comp_q;

  // pulldown default: low strap selects divide-by-two
  assign conv = rise & (half_rate_select | div_q);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_true_q <= 1'b0;
      clk_comp_q <= 1'b1;
      div_q      <= 1'b0;
    end else begin
      clk_true_q <= sample_clk_true;
      clk_comp_q <= sample_clk_comp;
      if (rise) begin
        div_q <= ~div_q;
      end
    end
  end

  // clamp and range detection in offset binary
  always @* begin
    or_flag = above_full_scale | below_full_scale;
    if (above_full_scale) begin
      ob_code = `CODE_MAX_OB;
    end else if (below_full_scale) begin
      ob_code = `CODE_MIN_OB;
    end else begin
      // exact full scales and mid-scale pass unflagged
      ob_code = analog_code;
    end
  end

  // flag rides in the same pipeline slot as its word
  sample_pipe #(
    .WIDTH (`WORD_W + 1),
    .DEPTH (`LATENCY)
  ) u_pipe (
    .clk      (clk),
    .rst_b    (rst_b),
    .adv      (conv),
    .in_data  ({or_flag, ob_code}),
    .out_data (pipe_out)
  );

  // words only count once the pipe holds real samples
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_q <= `CNT_ZERO;
    end else if (conv && fill_q != `LATENCY) begin
      fill_q <= fill_q + `CNT_ONE;
    end
  end

  assign fifo_in_valid = conv & (fill_q == `LATENCY);

  // a full fifo drops the newest word: a converter cannot stall its input
  word_fifo #(
    .WIDTH (`WORD_W + 1),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (pipe_out),
    .out_valid (word_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_out)
  );

  // twos complement: invert the msb of the offset binary word
  assign fmt_word = format_offset_bin ? fifo_out[`WORD_W-1:0] :
                    {~fifo_out[`MSB], fifo_out[`MSB-1:0]};

  // bus updates with data clock low, rises the cycle after: one-cycle high pulse
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_word_true <= `CODE_MID_OB;
      sample_word_comp <= ~`CODE_MID_OB;
      overrange_true   <= 1'b0;
      overrange_comp   <= 1'b1;
      out_clk_true     <= 1'b0;
      out_clk_comp     <= 1'b1;
      conv_clk_q       <= 1'b0;
    end else begin
      conv_clk_q <= 1'b0;
      if (word_valid && drain_ready) begin
        sample_word_true <= fmt_word;
        sample_word_comp <= ~fmt_word;
        overrange_true   <= fifo_out[`WORD_W];
        overrange_comp   <= ~fifo_out[`WORD_W];
        conv_clk_q       <= 1'b1;
      end
      out_clk_true <= conv_clk_q;
      out_clk_comp <= ~conv_clk_q;
    end
  end
  // fifo_in_ready low only when drain stalled four words
endmodule // adc_output_format_timing
`default_nettype wire

//--- test/adc_out_checker_properties.sv
`timescale 1ns/100ps
`default_nettype none
module adc_out_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // observed outputs
  input wire logic [11:0] sample_word_true,
  input wire logic [11:0] sample_word_comp,
  input wire logic        overrange_true,
  input wire logic        overrange_comp,
  input wire logic        out_clk_true,
  input wire logic        out_clk_comp,
  input wire logic        word_valid,
  input wire logic        word_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_comp_word; sample_word_comp == ~sample_word_true; endproperty
  property p_comp_flag; overrange_comp == ~overrange_true; endproperty
  property p_comp_clk; out_clk_comp == ~out_clk_true; endproperty
  property p_clk_cause; out_clk_true |-> $past(word_valid && word_ready, 2);
  endproperty
  property p_pop_clk; $changed(sample_word_true) |=> out_clk_true;
  endproperty
  property p_word_at_clk; out_clk_true |-> $stable(sample_word_true);
  endproperty
  property p_clk_pulse; out_clk_true |=> !out_clk_true; endproperty
  property p_word_hold; !(word_valid && word_ready) |=>
    $stable(sample_word_true) && $stable(overrange_true); endproperty
  // eleven conversions at least two cycles apart leave the bus idle long
  property p_no_early; $rose(rst_b) |-> !word_valid [*8]; endproperty
  property p_valid_hold; word_valid && !word_ready |=> word_valid;
  endproperty
  a_comp_word: assert property (p_comp_word) else $error("word pair");
  a_comp_flag: assert property (p_comp_flag) else $error("flag pair");
  a_comp_clk: assert property (p_comp_clk) else $error("clock pair");
  a_clk_cause: assert property (p_clk_cause) else $error("stray clk");
  a_pop_clk: assert property (p_pop_clk) else $error("missing clk");
  a_word_hold: assert property (p_word_hold) else $error("word moved");
  a_word_at_clk: assert property (p_word_at_clk) else $error("word skew");
  a_clk_pulse: assert property (p_clk_pulse) else $error("clock wide");
  a_no_early: assert property (p_no_early) else $error("early word");
  a_valid_hold: assert property (p_valid_hold) else $error("lost word");
  c_pop: cover property (word_valid && word_ready);
  c_flag: cover property ($rose(overrange_true));
  c_stall: cover property (word_valid && !word_ready);
endmodule // adc_out_checker
bind adc_output_format_timing adc_out_checker u_chk (.clk(clk),
  .rst_b(rst_b), .sample_word_true(sample_word_true),
  .sample_word_comp(sample_word_comp), .overrange_true(overrange_true),
  .overrange_comp(overrange_comp), .out_clk_true(out_clk_true),
  .out_clk_comp(out_clk_comp), .word_valid(word_valid),
  .word_ready(word_ready));
`default_nettype wire

//--- test/word_catcher.sv
`timescale 1ns/100ps
`default_nettype none
module word_catcher (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // converter output bus
  input  wire logic        out_clk_true,
  input  wire logic [11:0] sample_word_true,
  input  wire logic        overrange_true,
  // flow control
  input  wire logic        stall,
  output wire logic        word_ready
);
  logic [12:0] got [$];
  assign word_ready = !stall;
  // latch on the data clock edge only, flag kept with its word
  always @(posedge clk)
    if (rst_b && out_clk_true)
      got.push_back({overrange_true, sample_word_true});
endmodule // word_catcher
`default_nettype wire

//--- test/adc_output_format_timing_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_output_format_timing_tb;
  logic        clk, rst_b, sck, half, fmt, above, below, stall;
  logic [11:0] code, wt, wc;
  wire         ot, oc, ct, cc, vld, rdy;
  integer      fails, total_checks;
  logic [12:0] exp_q [$];
  adc_output_format_timing dut (.clk(clk), .rst_b(rst_b),
    .sample_clk_true(sck), .sample_clk_comp(~sck), .analog_code(code),
    .above_full_scale(above), .below_full_scale(below),
    .half_rate_select(half), .format_offset_bin(fmt),
    .sample_word_true(wt), .sample_word_comp(wc), .overrange_true(ot),
    .overrange_comp(oc), .out_clk_true(ct), .out_clk_comp(cc),
    .word_valid(vld), .word_ready(rdy));
  word_catcher rx (.clk(clk), .rst_b(rst_b), .out_clk_true(ct),
    .sample_word_true(wt), .overrange_true(ot), .stall(stall),
    .word_ready(rdy));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task check(input logic [12:0] seen, input logic [12:0] want);
    total_checks = total_checks + 1;
    if (seen !== want) begin
      fails = fails + 1;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task tally_and_finish;
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task restart(input logic h, input logic f, input logic s);
    rst_b <= 0; sck <= 0; half <= h; fmt <= f; stall <= s;
    repeat (2) @(posedge clk);
    rx.got.delete(); exp_q.delete();
    rst_b <= 1;
  endtask
  // half rate holds each value over two events, so either one converts
  task conv(input logic [11:0] c, input logic a, input logic b,
            input logic keep);
    logic [11:0] ob;
    ob = a ? 12'hFFF : b ? 12'h000 : c;
    if (keep) exp_q.push_back({a | b, fmt ? ob : {~ob[11], ob[10:0]}});
    code <= c; above <= a; below <= b;
    repeat (half ? 1 : 2) begin
      sck <= 1;
      repeat (2) @(posedge clk);
      sck <= 0;
      repeat (2) @(posedge clk);
    end
  endtask
  task data;
    conv(12'h123, 1, 0, 1);
    conv(12'hFFF, 0, 0, 1);
    conv(12'h800, 0, 0, 1);
    conv(12'h000, 0, 0, 1);
    conv(12'h5A5, 0, 1, 1);
    conv(12'h7FF, 0, 0, 1);
    conv(12'h3C3, 1, 1, 1);
    repeat (11) conv(12'h800, 0, 0, 0);
    repeat (30) @(posedge clk);
  endtask
  task compare;
    check(13'(rx.got.size()), 13'(exp_q.size()));
    foreach (exp_q[i])
      if (i < rx.got.size()) check(rx.got[i], exp_q[i]);
  endtask
  task sc_half_twos;
    restart(0, 0, 0);
    data;
    compare;
  endtask
  task sc_full_binary;
    restart(1, 1, 0);
    data;
    compare;
  endtask
  task sc_fill_stall;
    restart(1, 0, 1);
    data;
    check(13'(rx.got.size()), 13'h0);
    check({12'h0, vld}, 13'h1);
    while (exp_q.size() > 4) exp_q.pop_back();
    stall <= 0;
    repeat (30) @(posedge clk);
    compare;
    check({12'h0, vld}, 13'h0);
  endtask
  initial begin
    rst_b = 0; sck = 0; half = 0; fmt = 0; above = 0; below = 0;
    code = 12'h000; stall = 0; fails = 0; total_checks = 0;
    @(posedge clk);
    sc_half_twos;
    sc_full_binary;
    sc_fill_stall;
    tally_and_finish;
  end
  initial begin
    #75000;
    fails = fails + 1;
    tally_and_finish;
  end
endmodule // adc_output_format_timing_tb
`default_nettype wire
